/* xlate_diag_pkg.sv */
package xlate_diag_pkg;

  localparam logic [7:0] PAGE_SUPPORTED = 8'h00;
  localparam logic [7:0] PAGE_XLATE = 8'h40;
  localparam logic [7:0] PAGE_VENDOR_MIN = 8'h80;
  localparam logic [15:0] PAGE_LEN_SEND = 16'h000a;

  // Page code classes
  localparam logic [1:0] CLASS_SUPPORTED = 2'h0;
  localparam logic [1:0] CLASS_XLATE = 2'h1;
  localparam logic [1:0] CLASS_VENDOR = 2'h2;
  localparam logic [1:0] CLASS_RESERVED = 2'h3;

  // Byte positions in the incoming (sent) page
  localparam logic [3:0] BYTE_CODE = 4'h0;
  localparam logic [3:0] BYTE_SRC = 4'h4;
  localparam logic [3:0] BYTE_DST = 4'h5;
  localparam logic [3:0] BYTE_ADDR_FIRST = 4'h6;
  localparam logic [3:0] BYTE_ADDR_LAST = 4'hd;

  // Returned page layout
  localparam logic [6:0] HDR_BYTES = 7'h06;
  localparam logic [15:0] DESC_BYTES = 16'h0002;
  localparam int BIT_RSV = 7;
  localparam int BIT_SPARE_SEC = 6;
  localparam int BIT_SPARE_TRK = 5;

  localparam int FMT_W = 3;
  localparam logic [2:0] FMT_LBA = 3'h0;
  localparam logic [2:0] FMT_BFI = 3'h4;
  localparam logic [63:0] LBA_MASK = 64'hffffffff_00000000;

  localparam int MAX_ENTRIES = 8;
  localparam int CNT_W = 4;

  localparam logic [3:0] SENSE_NONE = 4'h0;
  localparam logic [3:0] SENSE_ILLEGAL = 4'h5;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASC_INV_PARAM = 8'h26;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RECV,
    ST_MAP,
    ST_SEND
  } fsm_e;

endpackage : xlate_diag_pkg

/* xlate_diag.sv */
`timescale 1ns/10ps
module xlate_diag
  import xlate_diag_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic en,
  input wire logic send_start,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  input wire logic [7:0] fmt_supported,
  output logic send_done,
  output logic check_cond,
  output logic [3:0] sense_key,
  output logic [7:0] sense_code,
  output logic [1:0] page_class,
  output logic map_req,
  output logic [2:0] map_src_fmt,
  output logic [2:0] map_dst_fmt,
  output logic [63:0] map_addr,
  input wire logic map_valid,
  input wire logic [63:0] map_entry,
  input wire logic map_done,
  input wire logic map_rsv,
  input wire logic map_spare_sec,
  input wire logic map_sec_known,
  input wire logic map_spare_trk,
  input wire logic map_trk_known,
  input wire logic rd_start,
  input wire logic out_ready,
  output logic out_valid,
  output logic [7:0] out_byte,
  output logic out_last,
  output logic rd_empty,
  output logic result_valid
);

  typedef struct packed {
    fsm_e fsm;
    logic [3:0] in_idx;
    logic [1:0] page_class;
    logic page_ok;
    logic [2:0] src;
    logic [2:0] dst;
    logic [63:0] addr;
    logic [CNT_W-1:0] cnt;
    logic [MAX_ENTRIES-1:0][63:0] ent;
    logic rsv;
    logic spare_sec;
    logic spare_trk;
    logic result_valid;
    logic [6:0] out_pos;
    logic out_valid;
    logic [7:0] out_byte;
    logic out_last;
    logic map_req;
    logic send_done;
    logic check_cond;
    logic [3:0] sense_key;
    logic [7:0] sense_code;
    logic rd_empty;
  } st_s;

  st_s st_q;
  st_s st_d;

  ////////////////////////////////////////////////////////////////////////
  // Returned page byte at a given position
  function automatic logic [7:0] page_byte(input st_s s, input logic [6:0] pos);
    logic [15:0] len;
    logic [5:0] off;
    logic [63:0] sh;
    len = DESC_BYTES + 16'({s.cnt, 3'b000});
    off = 6'(pos - HDR_BYTES);
    sh = s.ent[off[5:3]] << {off[2:0], 3'b000};
    case (pos)
      7'h00: page_byte = PAGE_XLATE;
      7'h01: page_byte = 8'h00;
      7'h02: page_byte = len[15:8];
      7'h03: page_byte = len[7:0];
      7'h04: page_byte = {5'h00, s.src};
      7'h05: page_byte = {s.rsv, s.spare_sec, s.spare_trk, 2'b00, s.dst};
      default: page_byte = sh[63:56];
    endcase
  endfunction : page_byte

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [6:0] nxt;
    logic [6:0] last_pos;
    logic [CNT_W-1:0] cnt_n;
    nxt = 7'h00;
    last_pos = 7'(HDR_BYTES + 7'({st_q.cnt, 3'b000}) - 7'h01);
    cnt_n = st_q.cnt;
    st_d = st_q;
    st_d.map_req = 1'b0;
    st_d.send_done = 1'b0;
    st_d.check_cond = 1'b0;
    st_d.rd_empty = 1'b0;
    case (st_q.fsm)
      ST_IDLE:
      begin
        if (send_start)
        begin
          st_d.fsm = ST_RECV;
          st_d.in_idx = 4'h0;
          st_d.result_valid = 1'b0;
          st_d.sense_key = SENSE_NONE;
          st_d.sense_code = ASC_NONE;
        end
        else if (rd_start)
        begin
          if (st_q.result_valid)
          begin
            st_d.fsm = ST_SEND;
            st_d.out_valid = 1'b0;
          end
          else
          begin
            st_d.rd_empty = 1'b1;
          end
        end
      end
      ST_RECV:
      begin
        if (in_valid)
        begin
          st_d.in_idx = st_q.in_idx + 4'h1;
          if (st_q.in_idx == BYTE_CODE)
          begin
            st_d.page_ok = (in_byte == PAGE_XLATE);
            if (in_byte == PAGE_SUPPORTED)
              st_d.page_class = CLASS_SUPPORTED;
            else if (in_byte == PAGE_XLATE)
              st_d.page_class = CLASS_XLATE;
            else if (in_byte >= PAGE_VENDOR_MIN)
              st_d.page_class = CLASS_VENDOR;
            else
              st_d.page_class = CLASS_RESERVED;
          end
          if (st_q.in_idx == BYTE_SRC)
            st_d.src = in_byte[FMT_W-1:0];
          if (st_q.in_idx == BYTE_DST)
            st_d.dst = in_byte[FMT_W-1:0];
          if (st_q.in_idx >= BYTE_ADDR_FIRST)
            st_d.addr = {st_q.addr[55:0], in_byte};
          if (st_q.in_idx == BYTE_ADDR_LAST)
          begin
            if (!st_q.page_ok || !fmt_supported[st_q.src] || !fmt_supported[st_q.dst])
            begin
              st_d.fsm = ST_IDLE;
              st_d.check_cond = 1'b1;
              st_d.send_done = 1'b1;
              st_d.sense_key = SENSE_ILLEGAL;
              st_d.sense_code = ASC_INV_PARAM;
            end
            else
            begin
              st_d.fsm = ST_MAP;
              st_d.map_req = 1'b1;
              st_d.cnt = '0;
            end
          end
        end
      end
      ST_MAP:
      begin
        if (map_valid && st_q.cnt < CNT_W'(MAX_ENTRIES))
        begin
          if (st_q.dst == FMT_LBA)
            st_d.ent[st_q.cnt[2:0]] = map_entry & LBA_MASK;
          else
            st_d.ent[st_q.cnt[2:0]] = map_entry;
          cnt_n = st_q.cnt + CNT_W'(1);
          st_d.cnt = cnt_n;
        end
        if (map_done)
        begin
          if (st_q.dst == FMT_BFI && cnt_n[0])
            st_d.cnt = cnt_n - CNT_W'(1);
          st_d.rsv = map_rsv;
          st_d.spare_sec = map_spare_sec & map_sec_known;
          st_d.spare_trk = map_spare_trk | ~map_trk_known;
          st_d.result_valid = 1'b1;
          st_d.send_done = 1'b1;
          st_d.fsm = ST_IDLE;
        end
      end
      ST_SEND:
      begin
        if (!st_q.out_valid || out_ready)
        begin
          if (st_q.out_valid && st_q.out_last)
          begin
            st_d.out_valid = 1'b0;
            st_d.out_last = 1'b0;
            st_d.result_valid = 1'b0;
            st_d.fsm = ST_IDLE;
          end
          else
          begin
            nxt = st_q.out_valid ? st_q.out_pos + 7'h01 : 7'h00;
            st_d.out_pos = nxt;
            st_d.out_valid = 1'b1;
            st_d.out_byte = page_byte(st_q, nxt);
            st_d.out_last = (nxt == last_pos);
          end
        end
      end
      default:
      begin
        st_d.fsm = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_q <= '0;
    else if (en)
      st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////
  assign send_done = st_q.send_done;
  assign check_cond = st_q.check_cond;
  assign sense_key = st_q.sense_key;
  assign sense_code = st_q.sense_code;
  assign page_class = st_q.page_class;
  assign map_req = st_q.map_req;
  assign map_src_fmt = st_q.src;
  assign map_dst_fmt = st_q.dst;
  assign map_addr = st_q.addr;
  assign out_valid = st_q.out_valid;
  assign out_byte = st_q.out_byte;
  assign out_last = st_q.out_last;
  assign rd_empty = st_q.rd_empty;
  assign result_valid = st_q.result_valid;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n || !en);

  sequence last_byte_in;
    st_q.fsm == ST_RECV && in_valid && st_q.in_idx == BYTE_ADDR_LAST;
  endsequence

  sequence illegal_seen;
    check_cond && send_done && sense_key == SENSE_ILLEGAL && sense_code == ASC_INV_PARAM;
  endsequence

  chk_class_xlate: assert property (
    st_q.fsm == ST_RECV && in_valid && st_q.in_idx == BYTE_CODE && in_byte == PAGE_XLATE
    |=> page_class == CLASS_XLATE)
    else $error("translate page code not classified");

  chk_bad_src: assert property (
    last_byte_in and (!fmt_supported[st_q.src]) |=> illegal_seen ##1 !check_cond)
    else $error("bad source format not rejected");

  chk_bad_dst: assert property (
    last_byte_in and (!fmt_supported[st_q.dst]) |=> illegal_seen and (!map_req))
    else $error("bad target format not rejected");

  chk_map_req: assert property (
    last_byte_in and (st_q.page_ok && fmt_supported[st_q.src] && fmt_supported[st_q.dst])
    |=> map_req && map_addr == {$past(st_q.addr[55:0]), $past(in_byte)} ##1 !map_req)
    else $error("map request or address wrong");

  chk_hdr_code: assert property (
    out_valid && st_q.out_pos == 7'h00 |-> out_byte == PAGE_XLATE)
    else $error("returned page code wrong");

  chk_len_lo: assert property (
    out_valid && st_q.out_pos == 7'h03 |-> out_byte == 8'(8'h02 + {st_q.cnt, 3'b000}))
    else $error("returned page length wrong");

  chk_fmt_echo: assert property (
    out_valid && st_q.out_pos == 7'h04 |-> out_byte == {5'h00, map_src_fmt})
    else $error("supplied format not echoed");

  chk_flag_byte: assert property (
    out_valid && st_q.out_pos == 7'h05
    |-> out_byte[2:0] == map_dst_fmt && out_byte[4:3] == 2'b00 && out_byte[7] == st_q.rsv)
    else $error("flag and format byte wrong");

  chk_last_pos: assert property (
    out_valid && out_last |-> st_q.out_pos == 7'(7'h05 + {st_q.cnt, 3'b000}))
    else $error("page ended at wrong byte");

  chk_spare_sec: assert property (
    st_q.fsm == ST_MAP && map_done && !map_sec_known |=> !st_q.spare_sec)
    else $error("spare sector flag set while unknown");

  chk_spare_trk: assert property (
    st_q.fsm == ST_MAP && map_done && !map_trk_known |=> st_q.spare_trk)
    else $error("spare track flag clear while unknown");

  chk_result_kept: assert property (
    result_valid && st_q.fsm == ST_IDLE && !send_start && !rd_start |=> result_valid)
    else $error("result lost before read");

endmodule : xlate_diag

/* mapper_model.sv */
`timescale 1ns/10ps
module mapper_model (
  input wire logic clk,
  input wire logic map_req,
  input wire logic [3:0] cnt,
  input wire logic [4:0] flg,
  output logic map_valid,
  output logic [63:0] map_entry,
  output logic map_done,
  output logic [4:0] map_flags
);
  // Entries arrive with a dead cycle between them; released lines show inverted data
  initial
  begin
    map_valid = 1'b0;
    map_done = 1'b0;
    map_entry = 64'h0;
    map_flags = ~flg;
    forever
    begin
      @(negedge clk);
      if (map_req)
      begin
        for (int k = 0; k < cnt; k++)
        begin
          map_valid = 1'b1;
          map_entry = 64'h8877665544332211 + 64'h0101010101010101 * k;
          @(negedge clk);
          map_valid = 1'b0;
          map_entry = ~map_entry;
          @(negedge clk);
        end
        map_done = 1'b1;
        map_flags = flg;
        @(negedge clk);
        map_done = 1'b0;
        map_flags = ~flg;
      end
    end
  end
endmodule : mapper_model

/* tb_translate_address_diag_page.sv */
`timescale 1ns/10ps
module tb_translate_address_diag_page;
  import xlate_diag_pkg::*;
  logic clk = 0, arst_n = 0, send_start = 0, in_valid = 0, rd_start = 0, out_ready = 0;
  logic en = 1'b1;
  logic [7:0] in_byte = 8'h00, fmt_supported = 8'h11;
  logic [3:0] cnt = 4'h0;
  logic [4:0] flg = 5'h00, mf;
  logic send_done, check_cond, map_req, map_valid, map_done, out_valid, out_last;
  logic rd_empty, result_valid;
  logic [3:0] sense_key;
  logic [7:0] sense_code, out_byte;
  logic [1:0] page_class;
  logic [2:0] map_src_fmt, map_dst_fmt;
  logic [63:0] map_addr, map_entry;
  int err_total = 0, compares = 0;

  xlate_diag xlate_diag_inst (.clk(clk), .arst_n(arst_n), .en(en), .send_start(send_start),
    .in_valid(in_valid), .in_byte(in_byte), .fmt_supported(fmt_supported),
    .send_done(send_done), .check_cond(check_cond), .sense_key(sense_key),
    .sense_code(sense_code), .page_class(page_class), .map_req(map_req),
    .map_src_fmt(map_src_fmt), .map_dst_fmt(map_dst_fmt), .map_addr(map_addr),
    .map_valid(map_valid), .map_entry(map_entry), .map_done(map_done), .map_rsv(mf[4]),
    .map_spare_sec(mf[3]), .map_sec_known(mf[2]), .map_spare_trk(mf[1]),
    .map_trk_known(mf[0]), .rd_start(rd_start), .out_ready(out_ready),
    .out_valid(out_valid), .out_byte(out_byte), .out_last(out_last), .rd_empty(rd_empty),
    .result_valid(result_valid));
  mapper_model mapper_model_inst (.clk(clk), .map_req(map_req), .cnt(cnt), .flg(flg),
    .map_valid(map_valid), .map_entry(map_entry), .map_done(map_done), .map_flags(mf));

  initial
  begin
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic send(input logic [7:0] code, src, dst, input logic [63:0] addr);
    logic [7:0] b[14];
    b[0] = code;
    b[1] = 8'h00;
    b[2] = 8'h00;
    b[3] = 8'h0a;
    b[4] = src;
    b[5] = dst;
    for (int i = 0; i < 8; i++) b[6 + i] = addr[63 - 8 * i -: 8];
    @(negedge clk) send_start = 1'b1;
    for (int i = 0; i < 14; i++)
    begin
      @(negedge clk) send_start = 1'b0;
      in_valid = 1'b1;
      in_byte = b[i];
    end
    @(negedge clk) in_valid = 1'b0;
  endtask : send

  task automatic reject(input logic [7:0] code, src, dst, input logic [1:0] pc);
    send(code, src, dst, 64'h0);
    chk("check_cond", 2'h3, {send_done, check_cond});
    chk("sense", 12'h526, {sense_key, sense_code});
    chk("page_class", pc, page_class);
  endtask : reject

  task automatic read(input logic [7:0] exp[$]);
    int i;
    i = 0;
    @(negedge clk) rd_start = 1'b1;
    for (int t = 0; t < 200 && i < exp.size(); t++)
    begin
      @(negedge clk) rd_start = 1'b0;
      out_ready = t[0];
      if (out_valid && out_ready)
      begin
        chk("out_byte", exp[i], out_byte);
        chk("out_last", i == exp.size() - 1, out_last);
        i++;
      end
    end
    chk("byte count", exp.size(), i);
    @(negedge clk) out_ready = 1'b0;
    @(negedge clk) chk("drained", 0, {out_valid, result_valid});
    rd_start = 1'b1;
    @(negedge clk) rd_start = 1'b0;
    chk("rd_empty", 1, rd_empty);
  endtask : read

  task automatic good(input logic [2:0] dst, input logic [3:0] c, input logic [4:0] f);
    logic [7:0] exp[$];
    logic [63:0] e;
    int n, w;
    cnt = c;
    flg = f;
    send(8'h40, 8'h00, {5'h0, dst}, 64'h12345678_00000000);
    chk("map_req", 5'h14, {map_req, page_class, check_cond, send_done});
    chk("sense clear", 12'h000, {sense_key, sense_code});
    chk("map fmts", {3'h0, dst}, {map_src_fmt, map_dst_fmt});
    chk("map_addr", 64'h12345678_00000000, map_addr);
    for (w = 0; w < 60 && send_done !== 1'b1; w++) @(negedge clk);
    chk("send_done", 1, send_done);
    repeat (3) @(negedge clk);
    chk("result_valid", 1, result_valid);
    // Clock enable low must freeze the held result and ignore a read request
    en = 1'b0;
    rd_start = 1'b1;
    repeat (4) @(negedge clk);
    rd_start = 1'b0;
    en = 1'b1;
    @(negedge clk) chk("frozen", 3'h4, {result_valid, out_valid, rd_empty});
    n = (c > 8) ? 8 : c;
    if (dst == FMT_BFI) n = n & ~1;
    exp = '{8'h40, 8'h00, 8'h00, 8'(2 + 8 * n), 8'h00};
    exp.push_back({f[4], f[3] & f[2], f[1] | ~f[0], 2'b00, dst});
    for (int k = 0; k < n; k++)
    begin
      e = 64'h8877665544332211 + 64'h0101010101010101 * k;
      if (dst == FMT_LBA) e[31:0] = 32'h0;
      for (int i = 0; i < 8; i++) exp.push_back(e[63 - 8 * i -: 8]);
    end
    read(exp);
  endtask : good

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  initial
  begin
    #100us;
    err_total++;
    conclude;
  end

  initial
  begin
    repeat (16) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    reject(8'h00, 8'h00, 8'h00, 2'h0);
    reject(8'h41, 8'h00, 8'h00, 2'h3);
    reject(8'h81, 8'h00, 8'h00, 2'h2);
    reject(8'h40, 8'h01, 8'h00, 2'h1);
    reject(8'h40, 8'h00, 8'h02, 2'h1);
    good(3'h0, 4'h2, 5'b10110);
    good(3'h4, 4'h3, 5'b01101);
    good(3'h0, 4'h9, 5'b00011);
    good(3'h0, 4'h0, 5'b10000);
    conclude;
  end
endmodule : tb_translate_address_diag_page
